// *** safety_fault_passivation_ack.sv ***
// Purpose: fault passivation and acknowledge handling of an eight-port safety I/O module
// Assumes: fault inputs and controller bytes come from logic on aclk
// Notes:   registers over AXI4-Lite; error numbers are not produced here
//
// Notes on behaviour
// [RL1] module error: passivate module, zero data
// [RL2] module error sets functional flag bit 0
// [RL3] module error: fault lamp, red flash, alarms
// [RL4] port error: passivate that port, zero data
// [RL5] any port error sets flag bit 1
// [RL6] feedback link error sets flag bit 2
// [RL7] per-port qualifier, cleared on fault
// [RL8] port error: fault lamp, red flash, alarms
// [RL9] communication error zeroes data while present
// [RL10] after communication error, await explicit reintegration
// [RL11] whole module passivates, manual reintegration only
// [RL12] reintegrate only after failure indication falls
// [RL13] faults gone: green flash, outgoing alarm
// [RL14] controller acknowledges; module is reintegrated
// [RL15] reintegrated: fault lamp off, steady green
// [RL16] port acknowledge pulse 500 ms +/-150
// [RL17] port acknowledge from output bit 0
// [RL18] pulse clears gone faults, others stay
// [RL19] port fault gone: request bit 7, green
// [RL20] acknowledged port reactivated, qualifier set
// [RL21] reactivated port: lamp off, steady green
// [RL22] time pulse, ignore outside 350..650 ms
// [RL23] flags clear once all faults reintegrated
`timescale 1ns/1ns
`include "safety_fault_cfg.svh"
module safety_fault_passivation_ack
	import safety_fault_pkg::*;
#(
	parameter logic [`TIMER_W-1:0] ACK_MIN_CYCLES = `TIMER_W'(`ACK_MIN_CYC),
	parameter logic [`TIMER_W-1:0] ACK_MAX_CYCLES = `TIMER_W'(`ACK_MAX_CYC),
	parameter logic [`TIMER_W-1:0] FLASH_CYCLES   = `TIMER_W'(`FLASH_HALF_CYC)
)
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [`ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [`ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 module_fault,
	input  wire logic                 comm_fault,
	input  wire logic [7:0]           port_fault,
	input  wire logic [7:0]           link_fault,
	input  wire logic [7:0]           func_out_byte,
	input  wire logic                 global_ack_input,
	input  wire logic                 reintegration_acknowledge,
	input  wire logic [63:0]          in_data_raw,
	input  wire logic [63:0]          out_data_raw,
	output logic [63:0]               in_data,
	output logic [63:0]               out_data,
	output func_in_t                  func_in_byte,
	output logic [7:0]                qualifier,
	output logic                      device_fault,
	output logic                      ack_request,
	output logic                      system_fault_indicator,
	output led_t                      module_error_indicator,
	output led_t [7:0]                port_indicator,
	output logic                      alarm_valid,
	output alarm_t                    alarm
);

	mod_state_t                state_reg;
	mod_state_t                state_next;
	logic                      mod_any;
	logic                      mod_ack;
	logic [7:0]                fault_now;
	logic [7:0]                passive_reg;
	logic [7:0]                gone;
	logic                      port_ack;
	logic                      phase;
	logic                      module_err_reg;
	logic                      link_err_reg;
	logic [`NUM_SRC-1:0]       src_reg;
	logic [`NUM_SRC-1:0]       src_now;
	logic [`NUM_SRC-1:0]       coming_reg;
	logic [`NUM_SRC-1:0]       going_reg;
	logic [`NUM_SRC-1:0]       coming_ev;
	logic [`NUM_SRC-1:0]       going_ev;
	logic [`NUM_SRC-1:0]       coming_clr;
	logic [`NUM_SRC-1:0]       going_clr;
	logic                      ctrl_alarm_en_reg;
	logic [31:0]               ack_count_reg;
	logic                      aw_full_reg;
	logic                      w_full_reg;
	logic                      aw_full_next;
	logic                      w_full_next;
	logic [`ADDR_W-1:0]        awaddr_reg;
	logic [31:0]               wdata_reg;
	logic [3:0]                wstrb_reg;
	logic                      wr_fire;

	function automatic logic [3:0] lowest_set(input logic [`NUM_SRC-1:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = `NUM_SRC - 1; i >= 0; i--)
			if (v[i])
				idx = 4'(i);
		return idx;
	endfunction

	function automatic led_t flash(input logic on, input led_t color);
		return on ? color : LED_OFF;
	endfunction

	// =====================================================================
	// helpers
	// [RL22] pulse timing
	ack_pulse_timer
	#(
		.MIN_CYCLES (ACK_MIN_CYCLES),
		.MAX_CYCLES (ACK_MAX_CYCLES)
	)
	u_ack_timer
	(
		.aclk     (aclk),
		.aresetn  (aresetn),
		// [RL17] acknowledge bit
		.pulse_in (func_out_byte[`FO_ACK_BIT]),
		.ack_ok   (port_ack)
	);

	flash_phase
	#(
		.HALF_CYCLES (FLASH_CYCLES)
	)
	u_flash
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.phase   (phase)
	);

	// =====================================================================
	// module state
	assign mod_any   = module_fault | comm_fault;
	assign mod_ack   = global_ack_input | reintegration_acknowledge;
	assign fault_now = port_fault | link_fault;
	assign gone      = passive_reg & ~fault_now;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN:
				// [RL1] passivate module
				if (mod_any)
					state_next = ST_PASSIVE;
			ST_PASSIVE:
				// [RL12] failure indication fell
				if (!mod_any)
					state_next = ST_ACKREQ;
			ST_ACKREQ:
				if (mod_any)
					state_next = ST_PASSIVE;
				// [RL14] controller acknowledge
				// [RL11] manual reintegration only
				else if (mod_ack)
					state_next = ST_RUN;
			default:
				state_next = ST_PASSIVE;
		endcase
	end

	// [RL10] hold until reintegrated
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_reg <= ST_RUN;
		else
			state_reg <= state_next;
	end

	// [RL2] module flag
	// [RL23] clear on reintegration
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			module_err_reg <= 1'b0;
		else if (module_fault)
			module_err_reg <= 1'b1;
		else if (state_reg == ST_ACKREQ && mod_ack)
			module_err_reg <= 1'b0;
	end

	// =====================================================================
	// port passivation
	// [RL4] passivate faulty port
	// [RL18] clear only gone faults
	// [RL20] reactivate acknowledged ports
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			passive_reg <= 8'h00;
		else
			passive_reg <= fault_now | (passive_reg & ~(port_ack ? gone : 8'h00));
	end

	// [RL6] link flag
	// [RL23] clear after acknowledge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			link_err_reg <= 1'b0;
		else if (|link_fault)
			link_err_reg <= 1'b1;
		else if (port_ack && !(|(passive_reg & ~gone)))
			link_err_reg <= 1'b0;
	end

	// =====================================================================
	// process data gating
	// [RL1] [RL4] [RL9] zero data
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			in_data  <= 64'h0;
			out_data <= 64'h0;
		end
		else
		begin
			for (int i = 0; i < `NUM_PORTS; i++)
			begin
				if (state_next != ST_RUN || passive_reg[i] || fault_now[i])
				begin
					in_data[8*i +: 8]  <= 8'h00;
					out_data[8*i +: 8] <= 8'h00;
				end
				else
				begin
					in_data[8*i +: 8]  <= in_data_raw[8*i +: 8];
					out_data[8*i +: 8] <= out_data_raw[8*i +: 8];
				end
			end
		end
	end

	// =====================================================================
	// status to controller
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			func_in_byte <= '0;
			qualifier    <= 8'hFF;
			device_fault <= 1'b0;
			ack_request  <= 1'b0;
		end
		else
		begin
			func_in_byte.module_err  <= module_err_reg;
			// [RL5] port flag
			func_in_byte.port_err    <= |passive_reg;
			func_in_byte.link_err    <= link_err_reg;
			func_in_byte.reserved    <= 4'h0;
			// [RL19] acknowledge request
			func_in_byte.ack_request <= |gone;
			// [RL7] qualifier bits
			qualifier                <= ~passive_reg;
			device_fault             <= mod_any;
			ack_request              <= state_reg == ST_ACKREQ;
		end
	end

	// =====================================================================
	// indicators
	// [RL3] [RL8] fault lamp
	// [RL15] [RL21] off when reintegrated
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			system_fault_indicator <= 1'b0;
		else
			system_fault_indicator <= state_reg != ST_RUN || (|passive_reg);
	end

	// [RL13] green flash request
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			module_error_indicator <= LED_OFF;
		else if (state_reg == ST_PASSIVE)
			module_error_indicator <= flash(phase, LED_RED);
		else if (state_reg == ST_ACKREQ)
			module_error_indicator <= flash(phase, LED_GREEN);
		else
			module_error_indicator <= LED_GREEN;
	end

	// [RL8] red flash, [RL19] green flash
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			port_indicator <= {`NUM_PORTS{LED_OFF}};
		else
			for (int i = 0; i < `NUM_PORTS; i++)
				if (fault_now[i])
					port_indicator[i] <= flash(phase, LED_RED);
				else if (passive_reg[i])
					port_indicator[i] <= flash(phase, LED_GREEN);
				else
					port_indicator[i] <= LED_GREEN;
	end

	// =====================================================================
	// diagnostic alarms
	assign src_now = {comm_fault, module_fault, fault_now};

	always_comb
	begin
		coming_ev = src_now & ~src_reg;
		going_ev  = {`NUM_SRC{1'b0}};
		going_ev[`NUM_PORTS-1:0] = ~fault_now & src_reg[`NUM_PORTS-1:0];
		// [RL13] module fault outgoing
		going_ev[`SRC_MODULE] = state_reg == ST_PASSIVE && !mod_any;
		coming_clr = {`NUM_SRC{1'b0}};
		going_clr  = {`NUM_SRC{1'b0}};
		if (|coming_reg)
			coming_clr = `NUM_SRC'(1) << lowest_set(coming_reg);
		else if (|going_reg)
			going_clr = `NUM_SRC'(1) << lowest_set(going_reg);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			src_reg <= {`NUM_SRC{1'b0}};
		else
			src_reg <= src_now;
	end

	// [RL3] [RL8] alarm queue, new event beats clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !ctrl_alarm_en_reg)
		begin
			coming_reg <= {`NUM_SRC{1'b0}};
			going_reg  <= {`NUM_SRC{1'b0}};
		end
		else
		begin
			coming_reg <= (coming_reg & ~coming_clr) | coming_ev;
			going_reg  <= (going_reg & ~going_clr) | going_ev;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			alarm_valid <= 1'b0;
			alarm       <= '0;
		end
		else
		begin
			alarm_valid <= ctrl_alarm_en_reg && (|coming_reg || |going_reg);
			alarm.going <= !(|coming_reg);
			alarm.source <= |coming_reg ? lowest_set(coming_reg) : lowest_set(going_reg);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ack_count_reg <= 32'h0;
		else if (port_ack || (state_reg == ST_ACKREQ && state_next == ST_RUN))
			ack_count_reg <= ack_count_reg + 32'h1;
	end

	// =====================================================================
	// AXI4-Lite slave
	assign wr_fire      = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign aw_full_next = (aw_full_reg || (s_axi_awvalid && s_axi_awready))
		&& !(s_axi_bvalid && s_axi_bready);
	assign w_full_next  = (w_full_reg || (s_axi_wvalid && s_axi_wready))
		&& !(s_axi_bvalid && s_axi_bready);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			aw_full_reg   <= aw_full_next;
			w_full_reg    <= w_full_next;
			s_axi_awready <= !aw_full_next;
			s_axi_wready  <= !w_full_next;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_reg <= '0;
			wdata_reg  <= 32'h0;
			wstrb_reg  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
				awaddr_reg <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid      <= 1'b0;
			s_axi_bresp       <= `RESP_OKAY;
			ctrl_alarm_en_reg <= `CTRL_RESET;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			if (awaddr_reg == `REG_CTRL)
			begin
				s_axi_bresp <= `RESP_OKAY;
				if (wstrb_reg[0])
					ctrl_alarm_en_reg <= wdata_reg[0];
			end
			else if (awaddr_reg == `REG_STATUS || awaddr_reg == `REG_ACKCNT)
				s_axi_bresp <= `RESP_OKAY;
			else
				s_axi_bresp <= `RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `RESP_OKAY;
			unique case (s_axi_araddr)
				`REG_CTRL:   s_axi_rdata <= {31'h0, ctrl_alarm_en_reg};
				`REG_STATUS: s_axi_rdata <= {13'h0, state_reg, func_in_byte, qualifier};
				`REG_ACKCNT: s_axi_rdata <= ack_count_reg;
				default:
				begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

endmodule

// *** safety_fault_cfg.svh ***
// Purpose: constants for the fault passivation and acknowledge block
// Assumes: 125 MHz module clock
// Notes:   times in ms, cycle counts derived from the clock rate
`ifndef SAFETY_FAULT_CFG_SVH
`define SAFETY_FAULT_CFG_SVH

// =====================================================================
// timing
`define CLK_KHZ         125000
`define ACK_MIN_MS      350
`define ACK_MAX_MS      650
`define ACK_MIN_CYC     (`ACK_MIN_MS * `CLK_KHZ)
`define ACK_MAX_CYC     (`ACK_MAX_MS * `CLK_KHZ)
`define FLASH_HALF_MS   250
`define FLASH_HALF_CYC  (`FLASH_HALF_MS * `CLK_KHZ)
`define TIMER_W         27

// =====================================================================
// ports, alarm sources
`define NUM_PORTS       8
`define NUM_SRC         10
`define SRC_MODULE      8
`define SRC_COMM        9
`define FO_ACK_BIT      0

// =====================================================================
// register map
`define ADDR_W          12
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_ACKCNT      12'h008
`define CTRL_RESET      1'h1
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// *** safety_fault_pkg.sv ***
// Purpose: types shared by the fault passivation block
// Assumes: nothing
// Notes:   functional input byte layout is the struct order, msb first
package safety_fault_pkg;

	typedef enum logic [2:0]
	{
		ST_RUN     = 3'b001,
		ST_PASSIVE = 3'b010,
		ST_ACKREQ  = 3'b100
	} mod_state_t;

	typedef enum logic [1:0]
	{
		LED_OFF   = 2'h0,
		LED_RED   = 2'h1,
		LED_GREEN = 2'h2
	} led_t;

	typedef struct packed
	{
		logic       ack_request;
		logic [3:0] reserved;
		logic       link_err;
		logic       port_err;
		logic       module_err;
	} func_in_t;

	typedef struct packed
	{
		logic       going;
		logic [3:0] source;
	} alarm_t;

endpackage

// *** ack_pulse_timer.sv ***
// Purpose: measures the width of the port acknowledge pulse
// Assumes: pulse_in is on the module clock
// Notes:   ack_ok pulses one cycle after the falling edge of a pulse in window
`timescale 1ns/1ns
`include "safety_fault_cfg.svh"
module ack_pulse_timer
#(
	parameter logic [`TIMER_W-1:0] MIN_CYCLES = `TIMER_W'(`ACK_MIN_CYC),
	parameter logic [`TIMER_W-1:0] MAX_CYCLES = `TIMER_W'(`ACK_MAX_CYC)
)
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pulse_in,
	output logic      ack_ok
);

	logic [`TIMER_W-1:0] width_reg;
	logic                last_reg;

	// =====================================================================
	// width counter, saturating
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			width_reg <= '0;
		else if (!pulse_in)
			width_reg <= '0;
		else if (width_reg != {`TIMER_W{1'b1}})
			width_reg <= width_reg + `TIMER_W'(1);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			last_reg <= 1'b0;
		else
			last_reg <= pulse_in;
	end

	// =====================================================================
	// [RL16] window check on fall
	// [RL22] reject short, long
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ack_ok <= 1'b0;
		else
			ack_ok <= last_reg && !pulse_in
				&& width_reg >= MIN_CYCLES && width_reg <= MAX_CYCLES;
	end

endmodule

// *** flash_phase.sv ***
// Purpose: square wave that paces the flashing indicators
// Assumes: runs from reset
// Notes:   phase toggles every HALF_CYCLES clocks
`timescale 1ns/1ns
`include "safety_fault_cfg.svh"
module flash_phase
#(
	parameter logic [`TIMER_W-1:0] HALF_CYCLES = `TIMER_W'(`FLASH_HALF_CYC)
)
(
	input  wire logic aclk,
	input  wire logic aresetn,
	output logic      phase
);

	logic [`TIMER_W-1:0] count_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_reg <= '0;
		else if (count_reg >= HALF_CYCLES - `TIMER_W'(1))
			count_reg <= '0;
		else
			count_reg <= count_reg + `TIMER_W'(1);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			phase <= 1'b0;
		else if (count_reg >= HALF_CYCLES - `TIMER_W'(1))
			phase <= ~phase;
	end

endmodule

// *** safety_fault_asserts.sv ***
// Purpose: port-level checks of fault passivation and acknowledge
// Assumes: one aclk domain, synchronous active-low reset
// Notes:   bound into the top module
`timescale 1ns/1ns
module safety_fault_asserts
	import safety_fault_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        module_fault,
	input wire logic        comm_fault,
	input wire logic [7:0]  port_fault,
	input wire logic [7:0]  link_fault,
	input wire logic        global_ack_input,
	input wire logic        reintegration_acknowledge,
	input wire logic [63:0] in_data,
	input wire logic [63:0] out_data,
	input wire func_in_t    func_in_byte,
	input wire logic [7:0]  qualifier,
	input wire logic        ack_request,
	input wire logic        system_fault_indicator,
	input wire led_t        module_error_indicator
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// =====================================================================
	// module and communication faults
	property p_mod_zero;
		module_fault |=> (in_data == 64'h0) && (out_data == 64'h0);
	endproperty
	a_mod_zero: assert property (p_mod_zero) else $error("data not zeroed");
	property p_mod_flag;
		module_fault |-> ##2 func_in_byte.module_err;
	endproperty
	a_mod_flag: assert property (p_mod_flag) else $error("no module flag");
	property p_sf_on;
		module_fault |-> ##2 system_fault_indicator;
	endproperty
	a_sf_on: assert property (p_sf_on) else $error("fault lamp off");
	property p_comm_zero;
		comm_fault |=> in_data == 64'h0;
	endproperty
	a_comm_zero: assert property (p_comm_zero) else $error("comm data kept");
	property p_hold_passive;
		(module_fault || comm_fault) [*2] |=> !ack_request;
	endproperty
	a_hold_passive: assert property (p_hold_passive) else $error("early request");
	property p_no_auto;
		ack_request && !global_ack_input && !reintegration_acknowledge
			&& !module_fault && !comm_fault |=> ack_request;
	endproperty
	a_no_auto: assert property (p_no_auto) else $error("reintegrated unasked");
	property p_run_green;
		ack_request && global_ack_input && !module_fault && !comm_fault
			|-> ##3 module_error_indicator == LED_GREEN;
	endproperty
	a_run_green: assert property (p_run_green) else $error("no steady green");

	// =====================================================================
	// port faults
	property p_qual_clr;
		(port_fault != 8'h00) |-> ##2 ((qualifier & $past(port_fault, 2)) == 8'h00);
	endproperty
	a_qual_clr: assert property (p_qual_clr) else $error("qualifier kept");
	property p_port_flag;
		(port_fault != 8'h00) |-> ##2 func_in_byte.port_err;
	endproperty
	a_port_flag: assert property (p_port_flag) else $error("no port flag");
	property p_link_flag;
		(link_fault != 8'h00) |-> ##[1:2] func_in_byte.link_err;
	endproperty
	a_link_flag: assert property (p_link_flag) else $error("no link flag");

	c_mod: cover property (module_fault ##1 !module_fault);
	c_reint: cover property ($fell(ack_request));
	c_qual: cover property ($rose(qualifier == 8'hFF));
endmodule

bind safety_fault_passivation_ack safety_fault_asserts safety_fault_asserts_inst (.*);

// *** safety_controller_model.sv ***
// Purpose: safety controller stand-in for acknowledges
// Assumes: one clock, pulse width given in clock cycles
// Notes:   module acknowledge waits delay cycles after the request
`timescale 1ns/1ns
module safety_controller_model
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ack_request,
	input  wire logic       use_rei,
	input  wire logic [3:0] delay,
	input  wire logic       pulse_go,
	input  wire logic [7:0] pw,
	output logic [7:0]      func_out_byte,
	output logic            global_ack_input,
	output logic            reintegration_acknowledge
);
	logic [7:0] pulse_reg;
	logic [3:0] wait_reg;

	assign func_out_byte = {7'h00, pulse_reg != 8'h00};
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pulse_reg <= 8'h00;
		else if (pulse_go)
			pulse_reg <= pw;
		else if (pulse_reg != 8'h00)
			pulse_reg <= pulse_reg - 8'h01;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !ack_request)
		begin
			wait_reg <= 4'h0;
			global_ack_input <= 1'b0;
			reintegration_acknowledge <= 1'b0;
		end
		else if (wait_reg < delay)
			wait_reg <= wait_reg + 4'h1;
		else
		begin
			global_ack_input <= !use_rei;
			reintegration_acknowledge <= use_rei;
		end
	end
endmodule

// *** safety_fault_passivation_ack_bench.sv ***
// Purpose: self-checking bench of the fault passivation block
// Assumes: shortened acknowledge window 20..40 cycles, flash 4
// Notes:   controller stand-in answers module requests
`timescale 1ns/1ns
`include "safety_fault_cfg.svh"
module safety_fault_passivation_ack_bench
	import safety_fault_pkg::*;
();
	localparam logic [63:0] IRAW = 64'h8877665544332211;
	localparam logic [63:0] ORAW = 64'h0123456789ABCDEF;
	localparam logic [63:0] MASK = 64'hFFFF00FFFF00FFFF;
	logic aclk = 1'b0, aresetn = 1'b0, module_fault = 1'b0, comm_fault = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, use_rei = 1'b0, pulse_go = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF, delay = 4'h0;
	logic [7:0] port_fault = 8'h00, link_fault = 8'h00, pw = 8'h00, func_out_byte, qualifier;
	logic [63:0] in_data_raw = IRAW, out_data_raw = ORAW, in_data, out_data;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic global_ack_input, reintegration_acknowledge, device_fault, ack_request;
	logic system_fault_indicator, alarm_valid;
	func_in_t func_in_byte;
	led_t module_error_indicator;
	led_t [7:0] port_indicator;
	alarm_t alarm;
	logic [4:0] last_alarm = 5'h00;
	int bad_count = 0, comparisons = 0, cycles = 0, n_alarm = 0;

	safety_fault_passivation_ack #(.ACK_MIN_CYCLES(27'h14), .ACK_MAX_CYCLES(27'h28),
		.FLASH_CYCLES(27'h4)) safety_fault_passivation_ack_inst (.*);
	safety_controller_model safety_controller_model_inst (.*);

	always #4 aclk = ~aclk;

	// =====================================================================
	// alarm monitor and hang limit
	always @(posedge aclk)
	begin
		cycles++;
		if (alarm_valid === 1'b1)
		begin
			last_alarm <= alarm;
			n_alarm++;
		end
		if (cycles == 6000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end

	task tally_and_finish();
		if (bad_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// =====================================================================
	// register bus
	task axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task reg_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er, string n);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		rs = s_axi_rresp;
		chk(n, e, s_axi_rdata);
		s_axi_rready <= 1'b0;
		chk("rresp", er, rs);
	endtask

	// =====================================================================
	// scenarios
	task t_regs();
		reg_chk(`REG_STATUS, 32'h000100FF, `RESP_OKAY, "status");
		reg_chk(`REG_CTRL, 32'h1, `RESP_OKAY, "ctrl");
		reg_chk(12'h00C, 32'h0, `RESP_SLVERR, "unmapped");
		axi_wr(12'h00C, 32'hFFFFFFFF, rs);
		chk("bresp", `RESP_SLVERR, rs);
		axi_wr(`REG_STATUS, 32'h0, rs);
		reg_chk(`REG_STATUS, 32'h000100FF, `RESP_OKAY, "status_ro");
		chk("in_data", IRAW, in_data);
		chk("out_data", ORAW, out_data);
	endtask

	task t_module(input bit comm, input bit rei, input logic [3:0] dl, input logic [31:0] cnt);
		int i;
		use_rei <= rei;
		delay <= dl;
		if (comm)
			comm_fault <= 1'b1;
		else
			module_fault <= 1'b1;
		cyc(10);
		chk("in_data", 64'h0, in_data);
		chk("out_data", 64'h0, out_data);
		if (!comm)
			chk("func_in", 8'h01, func_in_byte);
		chk("sys_fault", 1'b1, system_fault_indicator);
		chk("dev_fault", 1'b1, device_fault);
		chk("ack_req", 1'b0, ack_request);
		comm_fault <= 1'b0;
		module_fault <= 1'b0;
		for (i = 0; i < 20 && ack_request !== 1'b1; i++) @(posedge aclk);
		chk("held_data", 64'h0, in_data);
		for (i = 0; i < 40 && ack_request !== 1'b0; i++) @(posedge aclk);
		cyc(3);
		chk("in_data", IRAW, in_data);
		chk("mod_led", LED_GREEN, module_error_indicator);
		chk("sys_fault", 1'b0, system_fault_indicator);
		chk("func_in", 8'h00, func_in_byte);
		if (!comm)
			chk("alarm", 5'h18, last_alarm);
		reg_chk(`REG_ACKCNT, cnt, `RESP_OKAY, "ackcnt");
	endtask

	task pulse(input logic [7:0] w);
		@(posedge aclk);
		pw <= w;
		pulse_go <= 1'b1;
		@(posedge aclk);
		pulse_go <= 1'b0;
		cyc(w + 6);
	endtask

	task t_port();
		int k;
		axi_wr(`REG_CTRL, 32'h0, rs);
		k = n_alarm;
		port_fault <= 8'h24;
		link_fault <= 8'h20;
		cyc(4);
		chk("alarm_count", k, n_alarm);
		chk("qualifier", 8'hDB, qualifier);
		chk("func_in", 8'h06, func_in_byte);
		chk("in_data", IRAW & MASK, in_data);
		chk("out_data", ORAW & MASK, out_data);
		chk("sys_fault", 1'b1, system_fault_indicator);
		axi_wr(`REG_CTRL, 32'h1, rs);
		port_fault <= 8'h20;
		cyc(3);
		chk("func_in", 8'h86, func_in_byte);
		pulse(8'd19);
		chk("qualifier", 8'hDB, qualifier);
		pulse(8'd41);
		chk("qualifier", 8'hDB, qualifier);
		pulse(8'd20);
		chk("qualifier", 8'hDF, qualifier);
		chk("func_in", 8'h06, func_in_byte);
		port_fault <= 8'h00;
		link_fault <= 8'h00;
		cyc(4);
		chk("alarm", 5'h15, last_alarm);
		pulse(8'd40);
		chk("qualifier", 8'hFF, qualifier);
		chk("func_in", 8'h00, func_in_byte);
		chk("in_data", IRAW, in_data);
		chk("sys_fault", 1'b0, system_fault_indicator);
		chk("port_led", {8{LED_GREEN}}, port_indicator);
		reg_chk(`REG_ACKCNT, 32'h4, `RESP_OKAY, "ackcnt");
	endtask

	initial
	begin
		cyc(12);
		aresetn <= 1'b1;
		t_regs();
		t_module(1'b0, 1'b0, 4'hC, 32'h1);
		t_module(1'b1, 1'b1, 4'h0, 32'h2);
		t_port();
		tally_and_finish();
	end
endmodule
